// File: rtl/iitf_pkg.sv
// Constants, types and register map of the instruction timing and flag decoder.
package iitf_pkg;
    localparam logic [7:0] OFS_INSN = 8'h00;
    localparam logic [7:0] OFS_ATTR = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam int ATTR_PROT = 0;
    localparam int ATTR_TWO_REG = 1;
    localparam int ATTR_CROSS64 = 2;
    localparam int ATTR_RD = 3;
    localparam int ATTR_WR = 4;
    localparam int ATTR_UNCACHED = 5;
    localparam int ATTR_LOCK = 6;
    localparam int ATTR_RATIO3X = 7;
    localparam int ATTR_OUT_RANGE = 8;
    localparam int ATTR_MUL_LSB = 12;
    localparam int ATTR_INT_LSB = 16;
    localparam int STAT_DONE = 0;
    localparam int STAT_INVALID = 1;
    localparam int STAT_TRAP = 2;
    localparam logic [31:0] ATTR_RESET = 32'h0000_0000;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [9:0] CYC_ASCII = 10'h007;
    localparam logic [9:0] CYC_MUL_MIN = 10'h00d;
    localparam logic [3:0] CYC_MUL_SPAN = 4'h8;
    localparam logic [9:0] CYC_ALU = 10'h001;
    localparam logic [9:0] CYC_PRIV = 10'h009;
    localparam logic [9:0] CYC_BOUND_IN = 10'h00b;
    localparam logic [9:0] CYC_BOUND_OUT = 10'h014;
    localparam logic [9:0] CYC_SCAN = 10'h003;
    localparam logic [9:0] CYC_EA_TWO_REG = 10'h001;
    localparam logic [9:0] CYC_SPLIT_ONE = 10'h001;
    localparam logic [9:0] CYC_SPLIT_BOTH = 10'h002;
    localparam logic [9:0] CYC_UNCACHED_2X = 10'h002;
    localparam logic [9:0] CYC_UNCACHED_3X = 10'h004;
    localparam logic [4:0] BOUND_VECTOR = 5'h05;
    localparam logic [7:0] OP_ADJ_ADD = 8'h37;
    localparam logic [7:0] OP_ADJ_SUB = 8'h3f;
    localparam logic [7:0] OP_ADJ_DIV = 8'hd5;
    localparam logic [7:0] OP_ADJ_MUL = 8'hd4;
    localparam logic [7:0] OP_ADJ_BASE = 8'h0a;
    localparam logic [7:0] OP_PRIV = 8'h63;
    localparam logic [7:0] OP_BOUND = 8'h62;
    localparam logic [7:0] OP_ESC = 8'h0f;
    localparam logic [7:0] OP_SCAN_FWD = 8'hbc;
    localparam logic [7:0] OP_SCAN_REV = 8'hbd;
    localparam logic [5:0] OP_GROUP_HI = 6'h20;
    localparam logic [2:0] FAM_ADD = 3'h0;
    localparam logic [2:0] FAM_ADC = 3'h2;
    localparam logic [2:0] FAM_AND = 3'h4;
    typedef enum logic [2:0] {
        FX_MOD = 3'h0, FX_KEEP = 3'h1, FX_CLR = 3'h2, FX_SET = 3'h3, FX_UNDEF = 3'h4
    } iitf_fx_t;
    // Flag order from high bits to low: overflow, direction, interrupt, trap,
    // sign, zero, auxiliary carry, parity, carry.
    localparam logic [26:0] FLG_NONE = {FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP,
        FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP};
    localparam logic [26:0] FLG_ARITH = {FX_MOD, FX_KEEP, FX_KEEP, FX_KEEP, FX_MOD,
        FX_MOD, FX_MOD, FX_MOD, FX_MOD};
    localparam logic [26:0] FLG_LOGIC = {FX_CLR, FX_KEEP, FX_KEEP, FX_KEEP, FX_MOD,
        FX_MOD, FX_UNDEF, FX_MOD, FX_CLR};
    localparam logic [26:0] FLG_ADJ_AS = {FX_UNDEF, FX_KEEP, FX_KEEP, FX_KEEP, FX_UNDEF,
        FX_UNDEF, FX_MOD, FX_UNDEF, FX_MOD};
    localparam logic [26:0] FLG_ADJ_MD = {FX_UNDEF, FX_KEEP, FX_KEEP, FX_KEEP, FX_MOD,
        FX_MOD, FX_UNDEF, FX_MOD, FX_UNDEF};
    localparam logic [26:0] FLG_ZERO = {FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP, FX_KEEP,
        FX_MOD, FX_KEEP, FX_KEEP, FX_KEEP};
    typedef enum logic [3:0] {
        KIND_NONE = 4'h0, KIND_ADJ_ADD = 4'h1, KIND_ADJ_DIV = 4'h2, KIND_ADJ_MUL = 4'h3,
        KIND_ADJ_SUB = 4'h4, KIND_ADC = 4'h5, KIND_ADD = 4'h6, KIND_AND = 4'h7,
        KIND_PRIV = 4'h8, KIND_BOUND = 4'h9, KIND_SCAN_FWD = 4'ha, KIND_SCAN_REV = 4'hb
    } iitf_kind_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01} iitf_state_t;
    typedef struct packed {
        logic valid;
        iitf_kind_t kind;
        logic [9:0] base;
        logic [26:0] flags;
        logic mem;
        logic wbit;
        logic dbit;
    } iitf_dec_t;
endpackage

// File: rtl/iitf_core.sv
// Instruction timing and flag decoder with an AHB-Lite register slave.
`timescale 1ns/1ps
module iitf_core import iitf_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    output logic busy
);
    typedef struct packed {
        iitf_state_t st;
        logic [23:0] insn;
        logic [31:0] attr;
        logic [9:0] cycles;
        logic [9:0] cnt;
        logic [26:0] flags;
        iitf_kind_t kind;
        logic invalid;
        logic trap;
        logic wbit;
        logic dbit;
        logic [2:0] stat;
        logic [2:0] mask;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
    } iitf_regs_t;

    iitf_regs_t q;
    iitf_regs_t d;
    iitf_dec_t dec;
    logic [9:0] total;
    logic [9:0] pen;
    logic start;
    logic aph;
    logic [9:0] unc_pen;

    function automatic iitf_dec_t iitf_decode(input logic [23:0] b, input logic prot);
        iitf_dec_t r;
        r = '{valid: 1'b0, kind: KIND_NONE, base: 10'h000, flags: FLG_NONE,
            mem: 1'b0, wbit: 1'b0, dbit: 1'b0};
        case (b[7:0])
            OP_ADJ_ADD: begin
                r = '{1'b1, KIND_ADJ_ADD, CYC_ASCII, FLG_ADJ_AS, 1'b0, 1'b0, 1'b0};
            end
            OP_ADJ_SUB: begin
                r = '{1'b1, KIND_ADJ_SUB, CYC_ASCII, FLG_ADJ_AS, 1'b0, 1'b0, 1'b0};
            end
            OP_ADJ_DIV: begin
                if (b[15:8] == OP_ADJ_BASE) begin
                    r = '{1'b1, KIND_ADJ_DIV, CYC_ASCII, FLG_ADJ_MD,
                        1'b0, 1'b0, 1'b0};
                end
            end
            OP_ADJ_MUL: begin
                if (b[15:8] == OP_ADJ_BASE) begin
                    r = '{1'b1, KIND_ADJ_MUL, CYC_MUL_MIN, FLG_ADJ_MD,
                        1'b0, 1'b0, 1'b0};
                end
            end
            OP_PRIV: begin
                // Real mode has no privilege levels, so the opcode is refused there.
                r = '{prot, KIND_PRIV, CYC_PRIV, FLG_ZERO, b[15:14] != 2'b11,
                    1'b1, 1'b0};
            end
            OP_BOUND: begin
                r = '{1'b1, KIND_BOUND, CYC_BOUND_IN, FLG_NONE, b[15:14] != 2'b11,
                    1'b1, 1'b0};
            end
            OP_ESC: begin
                if (b[15:8] == OP_SCAN_FWD || b[15:8] == OP_SCAN_REV) begin
                    r = '{1'b1, (b[8] ? KIND_SCAN_REV : KIND_SCAN_FWD), CYC_SCAN, FLG_ZERO,
                        b[23:22] != 2'b11, 1'b1, 1'b0};
                end
            end
            default: begin
                if (b[7:2] == OP_GROUP_HI) begin
                    case (b[13:11])
                        FAM_ADD: r = '{1'b1, KIND_ADD, CYC_ALU, FLG_ARITH,
                            1'b0, 1'b0, 1'b0};
                        FAM_ADC: r = '{1'b1, KIND_ADC, CYC_ALU, FLG_ARITH,
                            1'b0, 1'b0, 1'b0};
                        FAM_AND: r = '{1'b1, KIND_AND, CYC_ALU, FLG_LOGIC,
                            1'b0, 1'b0, 1'b0};
                        default: r.valid = 1'b0;
                    endcase
                    r.mem = b[15:14] != 2'b11;
                end else if (b[7:6] == 2'b00 && b[2:1] != 2'b11) begin
                    case (b[5:3])
                        FAM_ADD: r = '{1'b1, KIND_ADD, CYC_ALU, FLG_ARITH,
                            1'b0, 1'b0, 1'b0};
                        FAM_ADC: r = '{1'b1, KIND_ADC, CYC_ALU, FLG_ARITH,
                            1'b0, 1'b0, 1'b0};
                        FAM_AND: r = '{1'b1, KIND_AND, CYC_ALU, FLG_LOGIC,
                            1'b0, 1'b0, 1'b0};
                        default: r.valid = 1'b0;
                    endcase
                    // Accumulator forms carry no modrm byte and never touch memory.
                    r.mem = !b[2] && b[15:14] != 2'b11;
                end
                r.wbit = b[0];
                r.dbit = b[1];
            end
        endcase
        return r;
    endfunction

    assign dec = iitf_decode(hwdata[23:0], q.attr[ATTR_PROT]);
    assign aph = hsel && htrans[1] && hready;
    assign start = q.dph_wr && q.dph_addr == OFS_INSN && q.st == ST_IDLE;
    assign unc_pen = q.attr[ATTR_RATIO3X] ? CYC_UNCACHED_3X : CYC_UNCACHED_2X;

    // Penalties only apply when the operand actually lives in memory.
    always_comb begin
        pen = 10'h000;
        if (dec.mem) begin
            if (q.attr[ATTR_TWO_REG]) begin
                pen = pen + CYC_EA_TWO_REG;
            end
            if (q.attr[ATTR_CROSS64]) begin
                if (q.attr[ATTR_RD] && q.attr[ATTR_WR]) begin
                    pen = pen + CYC_SPLIT_BOTH;
                end else if (q.attr[ATTR_RD] || q.attr[ATTR_WR]) begin
                    pen = pen + CYC_SPLIT_ONE;
                end
            end
            if (q.attr[ATTR_UNCACHED] || q.attr[ATTR_LOCK]) begin
                if (q.attr[ATTR_RD]) begin
                    pen = pen + unc_pen;
                end
                if (q.attr[ATTR_WR]) begin
                    pen = pen + unc_pen;
                end
            end
        end
        total = dec.base + pen;
        if (dec.kind == KIND_ADJ_MUL) begin
            // The data-dependent part is supplied by software and clipped to the span.
            if (q.attr[ATTR_MUL_LSB +: 4] > CYC_MUL_SPAN) begin
                total = total + {6'h00, CYC_MUL_SPAN};
            end else begin
                total = total + {6'h00, q.attr[ATTR_MUL_LSB +: 4]};
            end
        end
        if (dec.kind == KIND_BOUND && q.attr[ATTR_OUT_RANGE]) begin
            total = CYC_BOUND_OUT + pen;
            if (q.attr[ATTR_PROT]) begin
                total = total + {2'b00, q.attr[ATTR_INT_LSB +: 8]};
            end
        end
    end

    always_comb begin
        d = q;
        d.dph_wr = aph && hwrite;
        if (aph) begin
            d.dph_addr = haddr[7:0];
        end
        if (q.dph_wr) begin
            case (q.dph_addr)
                OFS_ATTR: d.attr = hwdata;
                OFS_MASK: d.mask = hwdata[2:0];
                default: d.attr = q.attr;
            endcase
        end
        if (aph && !hwrite) begin
            case (haddr[7:0])
                OFS_INSN: d.rdata = {8'h00, q.insn};
                OFS_ATTR: d.rdata = q.attr;
                OFS_RESULT: d.rdata = {5'h00, q.dbit, q.wbit, q.kind,
                    (q.trap ? BOUND_VECTOR : 5'h00), 3'h0, q.trap, q.invalid,
                    q.st == ST_EXEC, q.cycles};
                OFS_FLAGS: d.rdata = {5'h00, q.flags};
                OFS_STAT: d.rdata = {29'h0, q.stat};
                OFS_MASK: d.rdata = {29'h0, q.mask};
                default: d.rdata = 32'h0000_0000;
            endcase
            if (haddr[7:0] == OFS_STAT) begin
                d.stat = 3'h0;
            end
        end
        case (q.st)
            ST_IDLE: begin
                // A write to the instruction register while busy is dropped.
                if (start) begin
                    d.insn = hwdata[23:0];
                    d.kind = dec.kind;
                    d.flags = dec.flags;
                    d.wbit = dec.wbit;
                    d.dbit = dec.dbit;
                    d.invalid = !dec.valid;
                    d.trap = dec.valid && dec.kind == KIND_BOUND && q.attr[ATTR_OUT_RANGE];
                    if (dec.valid) begin
                        d.cycles = total;
                        d.cnt = total;
                        d.st = ST_EXEC;
                    end else begin
                        d.cycles = 10'h000;
                        d.stat[STAT_INVALID] = 1'b1;
                    end
                end
            end
            ST_EXEC: begin
                if (q.cnt == 10'h001) begin
                    d.st = ST_IDLE;
                    d.cnt = 10'h000;
                    d.stat[STAT_DONE] = 1'b1;
                    if (q.trap) begin
                        d.stat[STAT_TRAP] = 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt - 10'h001;
                end
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '{st: ST_IDLE, attr: ATTR_RESET, mask: MASK_RESET, kind: KIND_NONE,
                flags: FLG_NONE, default: '0};
        end else begin
            q <= d;
        end
    end

    // Zero wait states keep the slave simple; every answer is OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign irq = |(q.stat & q.mask);
    assign busy = q.st == ST_EXEC;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_start_opc(logic [7:0] opc);
        start && hwdata[7:0] == opc && dec.valid;
    endsequence
    sequence s_last;
        busy && q.cnt == 10'h001;
    endsequence

    sequence s_bound_out;
        start && hwdata[7:0] == OP_BOUND && dec.valid && q.attr[ATTR_OUT_RANGE];
    endsequence

    AST_BUSY_LEN: assert property (start && dec.valid && total == 10'h003
        |=> busy [*3] ##1 !busy)
        else $error("Busy did not last the computed count.");
    AST_DONE_SET: assert property (s_last |=> q.stat[STAT_DONE] && !busy)
        else $error("Completion did not set done.");
    AST_ADJ_ADD: assert property (s_start_opc(OP_ADJ_ADD)
        |=> q.cycles == 10'h007 && q.flags == FLG_ADJ_AS)
        else $error("Addition adjust timing or flags wrong.");
    AST_ADJ_SUB: assert property (s_start_opc(OP_ADJ_SUB) |=> q.cycles == 10'h007)
        else $error("Subtraction adjust timing wrong.");
    AST_PRIV_REAL: assert property (start && hwdata[7:0] == OP_PRIV
        && !q.attr[ATTR_PROT] |=> q.invalid && !busy && q.stat[STAT_INVALID])
        else $error("Privilege adjust accepted in real mode.");
    AST_TWO_REG: assert property (start && dec.valid && dec.mem
        && q.attr[ATTR_TWO_REG]
        && !q.attr[ATTR_CROSS64] && !q.attr[ATTR_UNCACHED] && !q.attr[ATTR_LOCK]
        && dec.kind != KIND_BOUND |=> q.cycles == $past(dec.base) + 10'h001)
        else $error("Two-register address penalty wrong.");
    AST_LOCK_UNC: assert property (start && dec.valid && dec.mem
        && dec.kind != KIND_BOUND
        && q.attr[ATTR_LOCK] && q.attr[ATTR_RD] && !q.attr[ATTR_WR] && q.attr[ATTR_RATIO3X]
        && !q.attr[ATTR_TWO_REG] && !q.attr[ATTR_CROSS64]
        |=> q.cycles == $past(dec.base) + 10'h004)
        else $error("Locked access penalty wrong.");
    // The trap is checked in two steps so that no long repetition has to be unrolled.
    AST_BOUND_TRAP: assert property (s_bound_out |=> q.trap && busy)
        else $error("Out-of-range bound was not marked as a trap.");
    AST_TRAP_SET: assert property (s_last && q.trap |=> q.stat[STAT_TRAP])
        else $error("Out-of-range bound did not raise the trap.");
    AST_IRQ: assert property (q.stat[STAT_DONE] && q.mask[STAT_DONE] |-> irq)
        else $error("Unmasked status did not raise the interrupt.");
endmodule

// File: tb/test_integer_instr_timing_flags.sv
// Self-checking testbench of the instruction timing and flag decoder.
`timescale 1ns/1ps
module test_integer_instr_timing_flags import iitf_pkg::*; ();
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic irq_exp = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    wire logic busy;
    wire logic [31:0] hrdata;
    int failures = 0;
    int n_compared = 0;

    iitf_core u_iitf_core (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .busy(busy));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The master holds each phase until hready is sampled high at a rising edge.
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, addr};
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rdata = hrdata;
        check_bit(hresp, 1'b0);
        check_bit(hreadyout, 1'b1);
    endtask

    task automatic ahb_w(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        ahb(1'b1, addr, data, unused);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, addr, 32'h0, r);
        check_word(r, exp);
    endtask

    // Counts the cycles busy stands; gives up a few cycles after a start that never came.
    task automatic wait_busy(output int n);
        n = 0;
        // Busy rises at the very edge that ends the write, so look before the next edge.
        for (int i = 0; i < 200; i++) begin
            #1;
            if (busy === 1'b1) begin
                n++;
            end else if (n > 0 || i > 6) begin
                break;
            end
            @(posedge ref_clk);
        end
    endtask

    // Argument wdt holds opcode bit 1, opcode bit 0 and the trap expectation.
    task automatic run(input logic [31:0] attr, input logic [31:0] insn, input logic [9:0] cyc,
                       input iitf_kind_t k, input logic [2:0] wdt, input logic [26:0] flg);
        int n;
        logic [31:0] r;
        logic [31:0] m;
        logic [31:0] e;
        e = {5'h0, wdt[2], wdt[1], k, wdt[0] ? BOUND_VECTOR : 5'h00, 3'h0, wdt[0], 2'h0, cyc};
        m = (k inside {KIND_ADC, KIND_ADD, KIND_AND}) ? 32'h07ff_1fff : 32'h01ff_1fff;
        ahb_w(OFS_ATTR, attr);
        ahb_w(OFS_INSN, insn);
        wait_busy(n);
        check_word(32'(n), {22'h0, cyc});
        ahb(1'b0, OFS_RESULT, 32'h0, r);
        check_word(r & m, e);
        rd_chk(OFS_FLAGS, {5'h0, flg});
        check_bit(irq, irq_exp);
        rd_chk(OFS_STAT, wdt[0] ? 32'h5 : 32'h1);
        check_bit(irq, 1'b0);
    endtask

    // An undecodable instruction must never raise busy and must flag itself invalid.
    task automatic run_bad(input logic [31:0] attr, input logic [31:0] insn);
        int n;
        logic [31:0] r;
        ahb_w(OFS_ATTR, attr);
        ahb_w(OFS_INSN, insn);
        wait_busy(n);
        check_word(32'(n), 32'h0);
        ahb(1'b0, OFS_RESULT, 32'h0, r);
        check_bit(r[11], 1'b1);
        check_bit(irq, irq_exp);
        rd_chk(OFS_INSN, insn);
        rd_chk(OFS_STAT, 32'h2);
        check_bit(irq, 1'b0);
    endtask

    initial begin
        #50000;
        failures++;
        complete_run;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check_bit(busy, 1'b0);
        check_bit(irq, 1'b0);
        rd_chk(OFS_ATTR, 32'h0);
        rd_chk(OFS_MASK, 32'h0);
        ahb_w(OFS_ATTR, 32'h0003_8123);
        rd_chk(OFS_ATTR, 32'h0003_8123);
        ahb_w(8'h18, 32'h1234_5678);
        rd_chk(8'h18, 32'h0);
        run(32'h0, 32'h0000_0037, 10'h007, KIND_ADJ_ADD, 3'h0, FLG_ADJ_AS);
        run(32'h0, 32'h0000_0ad5, 10'h007, KIND_ADJ_DIV, 3'h0, FLG_ADJ_MD);
        run(32'h0, 32'h0000_0ad4, 10'h00d, KIND_ADJ_MUL, 3'h0, FLG_ADJ_MD);
        run(32'h8000, 32'h0000_0ad4, 10'h015, KIND_ADJ_MUL, 3'h0, FLG_ADJ_MD);
        run(32'hf000, 32'h0000_0ad4, 10'h015, KIND_ADJ_MUL, 3'h0, FLG_ADJ_MD);
        run(32'h0, 32'h0000_003f, 10'h007, KIND_ADJ_SUB, 3'h0, FLG_ADJ_AS);
        run(32'h0, 32'h0000_c011, 10'h001, KIND_ADC, 3'h2, FLG_ARITH);
        run(32'h0, 32'h0000_0010, 10'h001, KIND_ADC, 3'h0, FLG_ARITH);
        run(32'h0, 32'h0000_0013, 10'h001, KIND_ADC, 3'h6, FLG_ARITH);
        run(32'h0, 32'h0000_d081, 10'h001, KIND_ADC, 3'h2, FLG_ARITH);
        run(32'h0, 32'h0000_0014, 10'h001, KIND_ADC, 3'h0, FLG_ARITH);
        run(32'h0, 32'h0000_c000, 10'h001, KIND_ADD, 3'h0, FLG_ARITH);
        run(32'h0, 32'h0000_0003, 10'h001, KIND_ADD, 3'h6, FLG_ARITH);
        run(32'h0, 32'h0000_c080, 10'h001, KIND_ADD, 3'h0, FLG_ARITH);
        run(32'h0, 32'h0000_0005, 10'h001, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'h0, 32'h0000_c021, 10'h001, KIND_AND, 3'h2, FLG_LOGIC);
        run(32'h0, 32'h0000_0022, 10'h001, KIND_AND, 3'h4, FLG_LOGIC);
        run(32'h0, 32'h0000_e083, 10'h001, KIND_AND, 3'h6, FLG_LOGIC);
        run(32'h0, 32'h0000_0024, 10'h001, KIND_AND, 3'h0, FLG_LOGIC);
        run_bad(32'h0, 32'h0000_c063);
        run(32'h1, 32'h0000_c063, 10'h009, KIND_PRIV, 3'h0, FLG_ZERO);
        run(32'h0003_0001, 32'h0000_0062, 10'h00b, KIND_BOUND, 3'h0, FLG_NONE);
        run(32'h100, 32'h0000_0062, 10'h014, KIND_BOUND, 3'h1, FLG_NONE);
        run(32'h0003_0101, 32'h0000_0062, 10'h017, KIND_BOUND, 3'h1, FLG_NONE);
        run(32'h0, 32'h00c0_bc0f, 10'h003, KIND_SCAN_FWD, 3'h0, FLG_ZERO);
        run(32'h0, 32'h00c0_bd0f, 10'h003, KIND_SCAN_REV, 3'h0, FLG_ZERO);
        run(32'h2, 32'h0000_bc0f, 10'h004, KIND_SCAN_FWD, 3'h0, FLG_ZERO);
        run(32'h2, 32'h0000_0001, 10'h002, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'h2, 32'h0000_c001, 10'h001, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'hc, 32'h0000_0001, 10'h002, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'h1c, 32'h0000_0001, 10'h003, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'h28, 32'h0000_0001, 10'h003, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'ha8, 32'h0000_0001, 10'h005, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'hb8, 32'h0000_0001, 10'h009, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'h50, 32'h0000_0001, 10'h003, KIND_ADD, 3'h2, FLG_ARITH);
        run(32'hc8, 32'h0000_0001, 10'h005, KIND_ADD, 3'h2, FLG_ARITH);
        ahb_w(OFS_MASK, 32'h2);
        rd_chk(OFS_MASK, 32'h2);
        irq_exp = 1'b1;
        run_bad(32'h0, 32'h0000_00ff);
        irq_exp = 1'b0;
        run(32'h0, 32'h0000_c000, 10'h001, KIND_ADD, 3'h0, FLG_ARITH);
        ahb_w(OFS_MASK, 32'h1);
        run_bad(32'h0, 32'h0000_00ff);
        irq_exp = 1'b1;
        run(32'h0, 32'h0000_0037, 10'h007, KIND_ADJ_ADD, 3'h0, FLG_ADJ_AS);
        complete_run;
    end
endmodule
